// File: rtl/uhef_defs.vh
// Constants of the host event and error flag block
`ifndef UHEF_DEFS_VH
`define UHEF_DEFS_VH

// ****************************************
// Register addresses
// ****************************************
`define UHEF_ADDR_W 4
`define UHEF_A_CTRL 4'h0
`define UHEF_A_CNT0 4'h1
`define UHEF_A_CNT1 4'h2
`define UHEF_A_EVT 4'h3
`define UHEF_A_ERR 4'h4
`define UHEF_A_STATE 4'h5

// ****************************************
// Controller control register bits
// ****************************************
`define UHEF_CC_RST 0
`define UHEF_CC_DETACH 1

// ****************************************
// Control register low bits
// ****************************************
`define UHEF_C0_ROLE 0
`define UHEF_C0_URST 1
`define UHEF_C0_IE_LO 2
`define UHEF_C0_IE_HI 7

// ****************************************
// Control register high bits
// ****************************************
`define UHEF_C1_CANCEL 1
`define UHEF_CNT1_RST 8'h01

// ****************************************
// Event register bits
// ****************************************
`define UHEF_EV_FRAME 0
`define UHEF_EV_DETACH 1
`define UHEF_EV_ATTACH 2
`define UHEF_EV_DONE 3
`define UHEF_EV_BRST 4
`define UHEF_EV_WAKE 5
`define UHEF_EV_RSVD 6
`define UHEF_EV_ABORT 7
// Bits kept through a controller soft reset
`define UHEF_EV_KEEP 8'h06

// ****************************************
// Error register bits
// ****************************************
`define UHEF_ER_MISSED 7
`define UHEF_ER_HS_LO 0
`define UHEF_ER_HS_HI 1
`define UHEF_HS_ACK 2'h0
`define UHEF_HS_NAK 2'h1
`define UHEF_HS_STALL 2'h2
`define UHEF_HS_NULL 2'h3
`define UHEF_ERR_RST 8'h03

// ****************************************
// Link state register bits
// ****************************************
`define UHEF_ST_SLEEP 2
`define UHEF_ST_TIMER 3

// ****************************************
// Role change delay
// ****************************************
`define UHEF_ROLE_DLY 4'h8

`endif

// File: rtl/uhef_sync_delay.v
// Delay line that lets a requested role take effect after a fixed time
module uhef_sync_delay (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Request and result
	input wire req,
	output reg cur
);
`include "uhef_defs.vh"

reg [3:0] cnt;

always @(posedge clock) begin
	if (!rst_b) begin
		cur <= 1'b0;
		cnt <= 4'h0;
	end else if (req == cur) begin
		cnt <= 4'h0;
	end else if (cnt == `UHEF_ROLE_DLY - 4'h1) begin
		cur <= req;
		cnt <= 4'h0;
	end else begin
		cnt <= cnt + 4'h1;
	end
end

endmodule // uhef_sync_delay

// File: rtl/uhef_top.v
// Host event flags, error status and role select of a USB host/function controller
//
// Chosen here: the placing of the registers and the address-and-strobe port.

module uhef_top (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Register port
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	input wire rd,
	output reg [7:0] rdata,
	// Events from the token engine and line monitor
	input wire ev_abort,
	input wire ev_wake_end,
	input wire ev_bus_reset_end,
	input wire ev_token_done,
	input wire ev_attach,
	input wire ev_detach,
	input wire ev_frame_start,
	input wire ev_frame_lost,
	input wire ev_xfer_end,
	input wire [1:0] ev_hs,
	input wire ev_frame_token,
	input wire ev_timer_stopped,
	// Controls to the token engine
	output wire host_role,
	output wire soft_reset,
	output wire bus_detach_ctrl,
	output wire token_cancel_en,
	output wire frame_timer_active,
	output wire sleep_request,
	// Interrupt
	output wire host_irq
);
`include "uhef_defs.vh"

// ****************************************
// Registers
// ****************************************
reg [7:0] controller_control_reg;
reg [7:0] ctrl_reg_low;
reg [7:0] ctrl_reg_high;
reg [7:0] event_flag_reg;
reg [7:0] error_status_reg;
reg [7:0] link_state_reg;
reg role_req;
reg [7:0] next_event;
reg [7:0] next_error;
wire role_now;
wire [7:0] ev_set;
wire [7:0] ev_wclr;
wire [7:0] er_set;
wire [7:0] er_wclr;
wire srst;

assign srst = controller_control_reg[`UHEF_CC_RST];
assign soft_reset = srst;
assign bus_detach_ctrl = controller_control_reg[`UHEF_CC_DETACH];
assign token_cancel_en = ctrl_reg_high[`UHEF_C1_CANCEL];
assign frame_timer_active = link_state_reg[`UHEF_ST_TIMER];
assign sleep_request = link_state_reg[`UHEF_ST_SLEEP];

// ****************************************
// Role select
// ****************************************
uhef_sync_delay u_role (
	.clock(clock),
	.rst_b(rst_b),
	.req(role_req),
	.cur(role_now)
);

assign host_role = role_now;

always @(posedge clock) begin
	if (!rst_b) begin
		role_req <= 1'b0;
	end else if (wr && addr == `UHEF_A_CNT0 && srst) begin
		role_req <= wdata[`UHEF_C0_ROLE];
	end
end

// ****************************************
// Control registers
// ****************************************
always @(posedge clock) begin
	if (!rst_b) begin
		controller_control_reg <= 8'h00;
		ctrl_reg_low <= 8'h00;
		ctrl_reg_high <= `UHEF_CNT1_RST;
		link_state_reg <= 8'h00;
	end else begin
		if (wr && addr == `UHEF_A_CTRL) begin
			controller_control_reg <= wdata;
		end
		if (wr && addr == `UHEF_A_CNT0) begin
			ctrl_reg_low[`UHEF_C0_IE_HI:`UHEF_C0_IE_LO] <= wdata[`UHEF_C0_IE_HI:`UHEF_C0_IE_LO];
		end
		// Bus reset request stays until the reset ends; ignored under soft reset
		if (srst || ev_bus_reset_end) begin
			ctrl_reg_low[`UHEF_C0_URST] <= 1'b0;
		end else if (wr && addr == `UHEF_A_CNT0 && wdata[`UHEF_C0_URST]) begin
			ctrl_reg_low[`UHEF_C0_URST] <= 1'b1;
		end
		if (wr && addr == `UHEF_A_CNT1) begin
			ctrl_reg_high <= wdata;
		end
		// Timer active: set by a started frame token, stop request or soft reset clears
		if (srst) begin
			link_state_reg[`UHEF_ST_TIMER] <= 1'b0;
			link_state_reg[`UHEF_ST_SLEEP] <= 1'b0;
		end else begin
			if (ev_frame_token) begin
				link_state_reg[`UHEF_ST_TIMER] <= 1'b1;
			end else if (ev_timer_stopped) begin
				link_state_reg[`UHEF_ST_TIMER] <= 1'b0;
			end else if (wr && addr == `UHEF_A_STATE && !wdata[`UHEF_ST_TIMER]) begin
				link_state_reg[`UHEF_ST_TIMER] <= 1'b0;
			end
			if (wr && addr == `UHEF_A_STATE) begin
				link_state_reg[`UHEF_ST_SLEEP] <= wdata[`UHEF_ST_SLEEP];
			end
		end
	end
end

// ****************************************
// Event flags
// ****************************************
assign ev_set[`UHEF_EV_FRAME] = ev_frame_start;
assign ev_set[`UHEF_EV_DETACH] = ev_detach;
assign ev_set[`UHEF_EV_ATTACH] = ev_attach;
assign ev_set[`UHEF_EV_DONE] = ev_token_done && !ev_abort;
assign ev_set[`UHEF_EV_BRST] = ev_bus_reset_end;
assign ev_set[`UHEF_EV_WAKE] = ev_wake_end;
assign ev_set[`UHEF_EV_RSVD] = 1'b0;
assign ev_set[`UHEF_EV_ABORT] = ev_abort && token_cancel_en;

assign ev_wclr = (wr && addr == `UHEF_A_EVT) ? ~wdata : 8'h00;

always @* begin
	next_event = (event_flag_reg & ~ev_wclr) | ev_set;
	if (srst) begin
		next_event = event_flag_reg & `UHEF_EV_KEEP & ~ev_wclr | ev_set & `UHEF_EV_KEEP;
	end
end

always @(posedge clock) begin
	if (!rst_b) begin
		event_flag_reg <= 8'h00;
	end else begin
		event_flag_reg <= next_event;
	end
end

// Enables sit at control bits 7..2 lined up with flags 5..0
assign host_irq = |(event_flag_reg[`UHEF_EV_WAKE:`UHEF_EV_FRAME] &
	ctrl_reg_low[`UHEF_C0_IE_HI:`UHEF_C0_IE_LO]);

// ****************************************
// Error status
// ****************************************
assign er_set = {ev_frame_lost && role_now, 7'h00};
assign er_wclr = (wr && addr == `UHEF_A_ERR) ? {~wdata[7:2], 2'h0} : 8'h00;

always @* begin
	next_error = (error_status_reg & ~er_wclr) | er_set;
	if (ev_xfer_end) begin
		next_error[`UHEF_ER_HS_HI:`UHEF_ER_HS_LO] = ev_hs;
	end
	if (srst) begin
		next_error = `UHEF_ERR_RST;
	end
end

always @(posedge clock) begin
	if (!rst_b) begin
		error_status_reg <= `UHEF_ERR_RST;
	end else begin
		error_status_reg <= next_error;
	end
end

// ****************************************
// Read port
// ****************************************
always @(posedge clock) begin
	if (!rst_b) begin
		rdata <= 8'h00;
	end else if (rd) begin
		case (addr)
			`UHEF_A_CTRL: rdata <= controller_control_reg;
			`UHEF_A_CNT0: rdata <= {ctrl_reg_low[7:1], role_now};
			`UHEF_A_CNT1: rdata <= ctrl_reg_high;
			`UHEF_A_EVT: rdata <= event_flag_reg;
			`UHEF_A_ERR: rdata <= error_status_reg;
			`UHEF_A_STATE: rdata <= link_state_reg;
			default: rdata <= 8'h00;
		endcase
	end else begin
		rdata <= 8'h00;
	end
end

endmodule // uhef_top

// File: verification/uhef_dev_model.sv
// Far side: bus activity of a device or hub, seen as one-cycle event pulses
module uhef_dev_model (
	// Clock
	input logic clock,
	// Events and handshake code
	output logic [10:0] ev,
	output logic [1:0] hs
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ev = 11'h000;
		hs = 2'h3;
	end
	// The code is only valid beside a transfer end, so it flips once that is over
	task automatic pulse(input logic [10:0] m, input logic [1:0] h);
		@(posedge clock);
		ev <= m;
		hs <= h;
		@(posedge clock);
		ev <= 11'h000;
		hs <= ~h;
		#1;
	endtask
endmodule // uhef_dev_model

// File: verification/uhef_chk_props.sv
// Port checks of the host event flag block
`include "uhef_defs.vh"
module uhef_chk (
	// Clock and reset
	input wire clock,
	input wire rst_b,
	// Register port
	input wire [3:0] addr,
	input wire [7:0] wdata,
	input wire wr,
	// Events
	input wire ev_abort,
	input wire ev_wake_end,
	input wire ev_bus_reset_end,
	input wire ev_token_done,
	input wire ev_attach,
	input wire ev_detach,
	input wire ev_frame_start,
	input wire ev_frame_token,
	input wire ev_timer_stopped,
	// Controls and interrupt
	input wire host_role,
	input wire soft_reset,
	input wire bus_detach_ctrl,
	input wire token_cancel_en,
	input wire frame_timer_active,
	input wire host_irq
);
	wire any_ev = ev_wake_end | ev_bus_reset_end | ev_token_done | ev_attach | ev_detach | ev_frame_start;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_role_gate: assert property ($changed(host_role) |-> $past(soft_reset, 8))
		else $error("role changed without soft reset");
	a_role_delay: assert property (wr && addr == `UHEF_A_CNT0 && soft_reset |=> $stable(host_role) [*6])
		else $error("role changed too early");
	a_timer_start: assert property (ev_frame_token && !soft_reset |=> frame_timer_active)
		else $error("timer active not set");
	a_timer_stop: assert property (ev_timer_stopped && !ev_frame_token |=> !frame_timer_active)
		else $error("timer active not cleared");
	a_abort_quiet: assert property (ev_abort && !any_ev && !wr && !host_irq |=> !host_irq)
		else $error("abort raised interrupt");
	a_clear_all: assert property (wr && addr == `UHEF_A_EVT && wdata == 8'h00 && !any_ev |=> !host_irq)
		else $error("flags not cleared by zero write");
	a_flags_hold: assert property (host_irq && !wr |=> host_irq || soft_reset)
		else $error("interrupt dropped without clear");
	a_ctrl_bits: assert property (wr && addr == `UHEF_A_CTRL |=>
		soft_reset == $past(wdata[0]) && bus_detach_ctrl == $past(wdata[1]))
		else $error("control bits not taken");
	a_cancel_bit: assert property (wr && addr == `UHEF_A_CNT1 |=> token_cancel_en == $past(wdata[1]))
		else $error("cancel enable not taken");
endmodule // uhef_chk

bind uhef_top uhef_chk i_chk (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
	.ev_abort(ev_abort), .ev_wake_end(ev_wake_end), .ev_bus_reset_end(ev_bus_reset_end),
	.ev_token_done(ev_token_done), .ev_attach(ev_attach), .ev_detach(ev_detach), .ev_frame_start(ev_frame_start),
	.ev_frame_token(ev_frame_token), .ev_timer_stopped(ev_timer_stopped), .host_role(host_role),
	.soft_reset(soft_reset), .bus_detach_ctrl(bus_detach_ctrl), .token_cancel_en(token_cancel_en),
	.frame_timer_active(frame_timer_active), .host_irq(host_irq));

// File: verification/usb_host_event_flags_tb.sv
// Testbench of the host event flag block
`include "uhef_defs.vh"
module usb_host_event_flags_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock, rst_b, wr, rd;
	logic [3:0] addr;
	logic [7:0] wdata;
	wire [7:0] rdata;
	wire [10:0] ev;
	wire [1:0] hs;
	wire host_role, soft_reset, bus_detach_ctrl, token_cancel_en, frame_timer_active, sleep_request, host_irq;
	int mismatches, comparisons;
	uhef_dev_model i_dev (.clock(clock), .ev(ev), .hs(hs));
	uhef_top i_dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
		.ev_abort(ev[7]), .ev_wake_end(ev[5]), .ev_bus_reset_end(ev[4]), .ev_token_done(ev[3]), .ev_attach(ev[2]),
		.ev_detach(ev[1]), .ev_frame_start(ev[0]), .ev_frame_lost(ev[6]), .ev_xfer_end(ev[8]), .ev_hs(hs),
		.ev_frame_token(ev[9]), .ev_timer_stopped(ev[10]), .host_role(host_role), .soft_reset(soft_reset),
		.bus_detach_ctrl(bus_detach_ctrl), .token_cancel_en(token_cancel_en),
		.frame_timer_active(frame_timer_active), .sleep_request(sleep_request), .host_irq(host_irq));
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic results();
		if (mismatches == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rreg(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		chk($sformatf("reg %h", a), exp, rdata);
	endtask
	task automatic t_reset();
		rreg(`UHEF_A_EVT, 8'h00);
		rreg(`UHEF_A_ERR, `UHEF_ERR_RST);
		rreg(4'hF, 8'h00);
	endtask
	task automatic t_flags();
		wreg(`UHEF_A_CNT1, 8'h03);
		i_dev.pulse(11'h088, 2'h0);
		rreg(`UHEF_A_EVT, 8'h80);
		i_dev.pulse(11'h03F, 2'h0);
		rreg(`UHEF_A_EVT, 8'hBF);
		wreg(`UHEF_A_EVT, 8'hBF);
		rreg(`UHEF_A_EVT, 8'hBF);
		wreg(`UHEF_A_CNT0, 8'hFC);
		wreg(`UHEF_A_EVT, 8'h00);
		chk("irq cleared", 8'h00, {7'h00, host_irq});
		i_dev.pulse(11'h080, 2'h0);
		chk("irq abort", 8'h00, {7'h00, host_irq});
		rreg(`UHEF_A_EVT, 8'h80);
		for (int i = 0; i < 6; i++) begin
			i_dev.pulse(11'h03F, 2'h0);
			wreg(`UHEF_A_EVT, 8'h01 << i);
			wreg(`UHEF_A_CNT0, 8'h04 << ((i + 1) % 6));
			chk("irq off", 8'h00, {7'h00, host_irq});
			wreg(`UHEF_A_CNT0, 8'h04 << i);
			chk("irq on", 8'h01, {7'h00, host_irq});
		end
	endtask
	task automatic t_soft();
		int n;
		logic [1:0] h;
		i_dev.pulse(11'h0BF, 2'h0);
		wreg(`UHEF_A_CTRL, 8'h03);
		rreg(`UHEF_A_EVT, `UHEF_EV_KEEP);
		wreg(`UHEF_A_CNT0, 8'h01);
		chk("role early", 8'h00, {7'h00, host_role});
		n = 0;
		while (host_role !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n == 20) begin
			mismatches++;
			results();
		end
		rreg(`UHEF_A_CNT0, 8'h01);
		wreg(`UHEF_A_CTRL, 8'h00);
		wreg(`UHEF_A_CNT0, 8'h00);
		wreg(`UHEF_A_CTRL, 8'h01);
		repeat (12) @(posedge clock);
		chk("role kept", 8'h01, {7'h00, host_role});
		wreg(`UHEF_A_CTRL, 8'h00);
		for (int c = 0; c < 4; c++) begin
			h = 2'(3 - c);
			i_dev.pulse(11'h140, h);
			rreg(`UHEF_A_ERR, {6'h20, h});
		end
		wreg(`UHEF_A_ERR, 8'h00);
		rreg(`UHEF_A_ERR, {6'h00, `UHEF_HS_ACK});
		i_dev.pulse(11'h200, 2'h0);
		chk("timer on", 8'h01, {7'h00, frame_timer_active});
		i_dev.pulse(11'h400, 2'h0);
		chk("timer off", 8'h00, {7'h00, frame_timer_active});
		wreg(`UHEF_A_STATE, 8'h04);
		chk("sleep on", 8'h01, {7'h00, sleep_request});
		wreg(`UHEF_A_STATE, 8'h00);
		chk("sleep off", 8'h00, {7'h00, sleep_request});
		i_dev.pulse(11'h240, 2'h0);
		wreg(`UHEF_A_CTRL, 8'h01);
		// Soft reset acts one edge after the control write lands
		@(posedge clock);
		#1;
		chk("timer reset", 8'h00, {7'h00, frame_timer_active});
		rreg(`UHEF_A_ERR, `UHEF_ERR_RST);
		rreg(`UHEF_A_STATE, 8'h00);
		wreg(`UHEF_A_CNT0, 8'h00);
		n = 0;
		while (host_role !== 1'b0 && n < 20) begin
			@(posedge clock);
			n++;
		end
		if (n == 20) begin
			mismatches++;
			results();
		end
		rreg(`UHEF_A_CNT0, 8'h00);
	endtask
	initial begin
		rst_b = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		mismatches = 0;
		comparisons = 0;
		repeat (16) @(posedge clock);
		rst_b <= 1'b1;
		t_reset();
		t_flags();
		t_soft();
		results();
	end
endmodule // usb_host_event_flags_tb
